/* File: tb/msc_mf_model.sv */
`timescale 1ns/1ns
`default_nettype none
module msc_mf_model
  import msc_pkg::*;
#(
  parameter int DEPTH = 64
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic acc,
  input  wire logic req,
  input  wire logic stb,
  input  wire logic clr,
  output logic      meas_ready,
  output logic      dvalid,
  output logic [3:0] ddata,
  output logic      empty,
  output logic      half,
  output logic      full
);
  int cnt;
  always @(posedge clk or posedge rst)
    if (rst || clr)
      cnt <= 0;
    else if (stb && cnt < DEPTH)
      cnt <= cnt + 1;
  assign empty = cnt == 0;
  assign half  = cnt >= DEPTH / 2;
  assign full  = cnt == DEPTH;
  // Data keeps moving while idle so a stale digit never looks valid
  always @(negedge clk or posedge rst)
    if (rst)
    begin
      meas_ready <= 0;
      dvalid     <= 0;
      ddata      <= 0;
    end
    else
    begin
      meas_ready <= acc && !req && !meas_ready && !dvalid;
      dvalid     <= req;
      ddata      <= ddata + 4'h7;
    end
endmodule // msc_mf_model
`default_nettype wire

/* File: tb/msc_seq_status_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module msc_sva
  import msc_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       INITIATE,
  input wire logic       HALT,
  input wire logic       MEM_RESET_CMD,
  input wire logic       DEV_CLEAR,
  input wire logic       SEL_DEV_CLEAR,
  input wire logic [1:0] FORMAT_SEL,
  input wire logic       DIGIT_VALID,
  input wire logic [3:0] DIGIT_DATA,
  input wire logic       MEM_EMPTY,
  input wire logic       MEM_FULL,
  input wire logic       SPOLL_EN,
  input wire logic       DATA_ACCEPT,
  input wire logic       DATA_SEND_REQUEST,
  input wire logic       STORE_STROBE,
  input wire logic [3:0] STORE_DIGIT,
  input wire logic       MEM_CLEAR,
  input wire logic       BINARY_FORWARD,
  input wire logic       ACCUMULATING,
  input wire logic [7:0] STATUS_BYTE,
  input wire logic       SERVICE_REQUEST,
  input wire logic       STATUS_LATCH_RESET
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  property p_lrst; STATUS_LATCH_RESET == (SPOLL_EN && DATA_ACCEPT); endproperty
  a_lrst: assert property (p_lrst) else $error("latch reset");
  property p_init;
    INITIATE && !ACCUMULATING && !DATA_SEND_REQUEST && !HALT && !MEM_RESET_CMD && !DEV_CLEAR && !SEL_DEV_CLEAR
    |=> ACCUMULATING;
  endproperty
  a_init: assert property (p_init) else $error("initiate");
  property p_clr; MEM_RESET_CMD || DEV_CLEAR || SEL_DEV_CLEAR |=> MEM_CLEAR; endproperty
  a_clr: assert property (p_clr) else $error("mem clear");
  property p_fmt; 1 |=> BINARY_FORWARD == ($past(FORMAT_SEL) == MSC_FMT_BINARY_FWD); endproperty
  a_fmt: assert property (p_fmt) else $error("format");
  property p_st; DIGIT_VALID && DATA_SEND_REQUEST && !MEM_FULL |=> STORE_STROBE && STORE_DIGIT == $past(DIGIT_DATA); endproperty
  a_st: assert property (p_st) else $error("store");
  property p_ovr; DIGIT_VALID && DATA_SEND_REQUEST && MEM_FULL |=> !STORE_STROBE && SERVICE_REQUEST; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun");
  property p_halt;
    HALT && ACCUMULATING && !MEM_RESET_CMD && !DEV_CLEAR && !SEL_DEV_CLEAR |=> SERVICE_REQUEST;
  endproperty
  a_halt: assert property (p_halt) else $error("halt");
  property p_srq; SERVICE_REQUEST && !STATUS_LATCH_RESET |=> SERVICE_REQUEST; endproperty
  a_srq: assert property (p_srq) else $error("srq drop");
  property p_emp; MEM_EMPTY |=> STATUS_BYTE[5:4] == MSC_OCC_EMPTY; endproperty
  a_emp: assert property (p_emp) else $error("empty");
  property p_full; MEM_FULL |=> STATUS_BYTE[5:4] == MSC_OCC_FULL; endproperty
  a_full: assert property (p_full) else $error("full");
endmodule // msc_sva
`default_nettype wire

/* File: tb/msc_seq_status_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module msc_seq_status_tb_top;
  logic CLK = 0, RST = 1, INITIATE = 0, HALT = 0, MEM_RESET_CMD = 0, DEV_CLEAR = 0;
  logic SEL_DEV_CLEAR = 0, DIGIT_COUNT_LOAD = 0, N_PRESET_LOAD = 0, SPOLL_EN = 0, DATA_ACCEPT = 0;
  logic [3:0] DIGIT_COUNT = 0, DIGIT_DATA, STORE_DIGIT;
  logic [15:0] N_PRESET = 0;
  logic [1:0] FORMAT_SEL = 0;
  logic MEAS_READY, DIGIT_VALID, MEM_EMPTY, MEM_HALF, MEM_FULL, DATA_SEND_REQUEST, STORE_STROBE;
  logic MEM_CLEAR, BINARY_FORWARD, ACCUMULATING, SERVICE_REQUEST, STATUS_LATCH_RESET;
  logic [7:0] STATUS_BYTE;
  logic [3:0] prev_dd = 0;
  int n_fail = 0, samples_checked = 0, n_st = 0, i;
  msc_seq_status i_dut (.*);
  msc_mf_model i_mf (.clk(CLK), .rst(RST), .acc(ACCUMULATING), .req(DATA_SEND_REQUEST),
    .stb(STORE_STROBE), .clr(MEM_CLEAR), .meas_ready(MEAS_READY), .dvalid(DIGIT_VALID),
    .ddata(DIGIT_DATA), .empty(MEM_EMPTY), .half(MEM_HALF), .full(MEM_FULL));
  initial forever #25 CLK = ~CLK;
  // Each stored digit must be the one the mainframe offered at the edge before
  always @(posedge CLK)
  begin
    if (STORE_STROBE === 1'b1)
    begin
      n_st++;
      chk("store digit", prev_dd, STORE_DIGIT);
    end
    prev_dd = DIGIT_DATA;
  end
  task summarize;
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task rd;
    @(negedge CLK) {SPOLL_EN, DATA_ACCEPT} = 2'b11;
    @(negedge CLK) {SPOLL_EN, DATA_ACCEPT} = 2'b00;
    repeat (2) @(negedge CLK);
  endtask
  // Program counts, then initiate, then wait bounded for the run to end
  task start(input logic [3:0] t, input logic [15:0] n, input int hlt);
    @(negedge CLK) {DIGIT_COUNT, N_PRESET, DIGIT_COUNT_LOAD, N_PRESET_LOAD} = {t, n, 2'b11};
    FORMAT_SEL = (t == 4'h1) ? 2'h2 : 2'($urandom);
    n_st = 0;
    @(negedge CLK) {DIGIT_COUNT_LOAD, N_PRESET_LOAD, INITIATE} = 3'b001;
    @(negedge CLK) INITIATE = 0;
    if (hlt)
    begin
      @(negedge CLK) HALT = 1;
      @(negedge CLK) HALT = 0;
    end
    for (i = 0; i < 4000 && ACCUMULATING !== 1'b0; i++) @(negedge CLK);
    repeat (3) @(negedge CLK);
    chk("run end", 1'b0, ACCUMULATING);
    chk("format", FORMAT_SEL == 2'h2, BINARY_FORWARD);
  endtask
  logic [3:0] tt [5] = '{4'h0, 4'h1, 4'h3, 4'hf, 4'h1};
  logic [15:0] nn [5] = '{16'h0001, 16'h0000, 16'h0002, 16'h0002, 16'h0010};
  int te, nd;
  initial
  begin
    #2000000 n_fail++;
    summarize;
  end
  initial
  begin
    void'($urandom(48858));
    nn[1] = 16'($urandom_range(9, 1));
    repeat (16) @(negedge CLK);
    RST = 0;
    @(negedge CLK);
    chk("status after reset", 8'h00, STATUS_BYTE);
    for (int k = 0; k < 5; k++)
    begin
      te = tt[k] == 0 ? 1 : (tt[k] > 13 ? 13 : tt[k]);
      nd = nn[k][7:4] * 10 + nn[k][3:0];
      start(tt[k], nn[k], 0);
      chk("stored digits", 16'(te * nd), 16'(n_st));
      chk("status done", 8'h60, STATUS_BYTE);
      chk("srq done", 1'b1, SERVICE_REQUEST);
      rd();
      chk("status read", 8'h20, STATUS_BYTE);
      chk("srq read", 1'b0, SERVICE_REQUEST);
      @(negedge CLK) MEM_RESET_CMD = 1;
      @(negedge CLK) MEM_RESET_CMD = 0;
      repeat (2) @(negedge CLK);
      chk("status reset", 8'h00, STATUS_BYTE);
    end
    start(4'hd, 16'h0009, 1);
    chk("sync bit", 1'b1, STATUS_BYTE[1]);
    chk("no done", 1'b0, STATUS_BYTE[6]);
    rd();
    chk("srq halt read", 1'b0, SERVICE_REQUEST);
    @(negedge CLK) SEL_DEV_CLEAR = 1;
    @(negedge CLK) SEL_DEV_CLEAR = 0;
    start(4'hd, 16'h0009, 0);
    chk("overrun", 8'h1a, STATUS_BYTE);
    rd();
    chk("overrun kept", 8'h1a, STATUS_BYTE);
    @(negedge CLK) DEV_CLEAR = 1;
    @(negedge CLK) DEV_CLEAR = 0;
    repeat (2) @(negedge CLK);
    chk("after clear", 8'h0a, STATUS_BYTE);
    chk("srq kept", 1'b1, SERVICE_REQUEST);
    rd();
    chk("all clear", 8'h00, STATUS_BYTE);
    summarize;
  end
endmodule // msc_seq_status_tb_top
bind msc_seq_status msc_sva i_sva (.*);
`default_nettype wire

/* File: verilog/msc_decade.sv */
`timescale 1ns/1ns
`default_nettype none

module msc_decade
  import msc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [3:0] preset,
  input  wire logic       dec,
  output logic [3:0]      value,
  output logic            is_zero
);

  logic [3:0] value_r;
  logic [3:0] value_nxt;

  always_comb
  begin
    value_nxt = value_r;
    if (load)
    begin
      value_nxt = (preset > MSC_BCD_MAX) ? MSC_BCD_MAX : preset;
    end
    else if (dec)
    begin
      value_nxt = (value_r == 4'h0) ? MSC_BCD_MAX : value_r - 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      value_r <= 4'h0;
    end
    else
    begin
      value_r <= value_nxt;
    end
  end

  assign value = value_r;
  assign is_zero = (value_r == 4'h0);

endmodule // msc_decade

`default_nettype wire

/* File: verilog/msc_pkg.sv */
package msc_pkg;

  localparam int unsigned MSC_MAX_DIGITS = 13;
  localparam logic [3:0] MSC_DIGITS_MAX = 4'hd;
  localparam logic [3:0] MSC_DIGITS_MIN = 4'h1;
  localparam logic [3:0] MSC_DIGITS_RST = 4'hd;
  localparam logic [15:0] MSC_NPRESET_RST = 16'h0001;
  localparam logic [3:0] MSC_BCD_MAX = 4'h9;
  localparam int unsigned MSC_DECADES = 4;

  localparam logic [1:0] MSC_FMT_BINARY_FWD = 2'h2;

  localparam int unsigned MSC_BIT_SYNC_ERR = 1;
  localparam int unsigned MSC_BIT_OVERRUN = 3;
  localparam int unsigned MSC_BIT_OCC_LOW = 4;
  localparam int unsigned MSC_BIT_OCC_HIGH = 5;
  localparam int unsigned MSC_BIT_COUNT_DONE = 6;

  localparam logic [1:0] MSC_OCC_EMPTY = 2'h0;
  localparam logic [1:0] MSC_OCC_BELOW_HALF = 2'h2;
  localparam logic [1:0] MSC_OCC_ABOVE_HALF = 2'h3;
  localparam logic [1:0] MSC_OCC_FULL = 2'h1;

  typedef enum logic [1:0]
  {
    MSC_IDLE = 2'b00,
    MSC_WAIT = 2'b01,
    MSC_XFER = 2'b11
  } msc_state_t;

endpackage

/* File: verilog/msc_seq_status.sv */
// What this block does
// - Store only the programmed digit count per measurement, never below 1 or above 13.
// - Digit counter preset with digit count; its borrow gates the send request.
// - Hold 16-bit count preset in a register, load independent cascaded decades.
// - Four decimal decades, each programmable 0 to 9.
// - Measurement counter end sets status bit 6, all measurements done.
// - Initiate starts counting and stores exactly the programmed measurements.
// - Digit count one stores one digit per measurement.
// - Format setting 2 selects binary, non-reversed read-out.
// - Completion raises service request with count done and occupancy shown.
// - Halt before completion latches sync error and requests service.
// - Storing into full memory latches bit 3 overrun and requests service.
// - Status read clears a latched bit only if its cause ended before.
// - Occupancy bits 4 and 5 are unlatched and follow the memory flags one clock later.
// - After overrun then memory reset, next read still shows latched bits.
// - After memory reset with nothing pending, status reads all zero.
// - Occupancy pattern 10 means memory holds data, below half full.
// - Memory reset, device clear and selected device clear empty memory.
// - Status latch reset pulses on serial poll enable with data accept.
`timescale 1ns/1ns
`default_nettype none

module msc_seq_status
  import msc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        INITIATE,
  input  wire logic        HALT,
  input  wire logic        MEM_RESET_CMD,
  input  wire logic        DEV_CLEAR,
  input  wire logic        SEL_DEV_CLEAR,
  input  wire logic [3:0]  DIGIT_COUNT,
  input  wire logic        DIGIT_COUNT_LOAD,
  input  wire logic [15:0] N_PRESET,
  input  wire logic        N_PRESET_LOAD,
  input  wire logic [1:0]  FORMAT_SEL,
  input  wire logic        MEAS_READY,
  input  wire logic        DIGIT_VALID,
  input  wire logic [3:0]  DIGIT_DATA,
  input  wire logic        MEM_EMPTY,
  input  wire logic        MEM_HALF,
  input  wire logic        MEM_FULL,
  input  wire logic        SPOLL_EN,
  input  wire logic        DATA_ACCEPT,
  output logic             DATA_SEND_REQUEST,
  output logic             STORE_STROBE,
  output logic [3:0]       STORE_DIGIT,
  output logic             MEM_CLEAR,
  output logic             BINARY_FORWARD,
  output logic             ACCUMULATING,
  output logic [7:0]       STATUS_BYTE,
  output logic             SERVICE_REQUEST,
  output logic             STATUS_LATCH_RESET
);

  msc_state_t  state_r;
  msc_state_t  state_nxt;
  logic [3:0]  digits_r;
  logic [3:0]  digits_nxt;
  logic [3:0]  dig_cnt_r;
  logic [3:0]  dig_cnt_nxt;
  logic [15:0] npre_r;
  logic [15:0] npre_nxt;
  logic        fmt_r;
  logic        fmt_nxt;
  logic        store_r;
  logic        store_nxt;
  logic [3:0]  sdig_r;
  logic [3:0]  sdig_nxt;
  logic        clr_r;
  logic        clr_nxt;
  logic        done_r;
  logic        done_nxt;
  logic        ovr_r;
  logic        ovr_nxt;
  logic        sync_r;
  logic        sync_nxt;
  logic [7:0]  stb_r;
  logic [7:0]  stb_nxt;
  logic [1:0]  occ;
  logic        mem_clear_req;
  logic        status_read;
  logic        n_load;
  logic        meas_end;
  logic        count_done_to_latch;
  logic        overrun_event;
  logic        sync_event;
  logic        digit_take;
  logic        digit_borrow;
  logic [3:0]  dec_en;
  logic [3:0]  dec_zero;
  logic [3:0]  dec_val [MSC_DECADES];
  logic        n_at_one;

  assign mem_clear_req = MEM_RESET_CMD | DEV_CLEAR | SEL_DEV_CLEAR;
  assign status_read = SPOLL_EN & DATA_ACCEPT;

  // All decades share one load; each upper enable is the lower enable gated by the lower decade's zero, so borrows cascade
  genvar gi;
  generate
    for (gi = 0; gi < MSC_DECADES; gi++)
    begin : g_dec
      if (gi == 0)
      begin : g_lsd
        assign dec_en[gi] = meas_end & ~n_at_one;
      end
      else
      begin : g_upper
        assign dec_en[gi] = dec_en[gi-1] & dec_zero[gi-1];
      end
      msc_decade u_decade
      (
        .clk     (CLK),
        .rst     (RST),
        .load    (n_load),
        .preset  (npre_r[4*gi +: 4]),
        .dec     (dec_en[gi]),
        .value   (dec_val[gi]),
        .is_zero (dec_zero[gi])
      );
    end
  endgenerate

  // Preset 0000 runs the full 10000 measurements, as the cascade wraps through 9999
  assign n_at_one = (dec_val[0] == 4'h1) & (&dec_zero[3:1]);
  assign n_load = (state_r == MSC_IDLE) & INITIATE & ~mem_clear_req;

  // Digit transfer: borrow of the counter ends the request for this measurement
  assign digit_take = (state_r == MSC_XFER) & DIGIT_VALID;
  assign digit_borrow = digit_take & (dig_cnt_r == 4'h1);
  // A write strobe still in flight when the full flag rises is refused by memory, so it counts too
  assign overrun_event = (digit_take | store_r) & MEM_FULL;
  assign meas_end = digit_borrow & ~MEM_FULL;
  assign count_done_to_latch = meas_end & n_at_one;
  assign sync_event = (HALT & (state_r != MSC_IDLE) & ~mem_clear_req) | overrun_event;

  always_comb
  begin
    state_nxt = state_r;
    dig_cnt_nxt = dig_cnt_r;
    store_nxt = 1'b0;
    sdig_nxt = sdig_r;
    unique case (state_r)
      MSC_IDLE:
      begin
        if (n_load)
        begin
          state_nxt = MSC_WAIT;
        end
      end
      MSC_WAIT:
      begin
        if (MEAS_READY)
        begin
          dig_cnt_nxt = digits_r;
          state_nxt = MSC_XFER;
        end
      end
      MSC_XFER:
      begin
        if (digit_take & ~MEM_FULL)
        begin
          store_nxt = 1'b1;
          sdig_nxt = DIGIT_DATA;
          dig_cnt_nxt = dig_cnt_r - 4'h1;
        end
        if (overrun_event)
        begin
          state_nxt = MSC_IDLE;
        end
        else if (digit_borrow)
        begin
          state_nxt = n_at_one ? MSC_IDLE : MSC_WAIT;
        end
      end
    endcase
    if (mem_clear_req | overrun_event | (HALT & (state_r != MSC_IDLE)))
    begin
      state_nxt = MSC_IDLE;
    end
  end

  always_comb
  begin
    digits_nxt = digits_r;
    npre_nxt = npre_r;
    fmt_nxt = (FORMAT_SEL == MSC_FMT_BINARY_FWD);
    clr_nxt = mem_clear_req;
    if (DIGIT_COUNT_LOAD)
    begin
      if (DIGIT_COUNT > MSC_DIGITS_MAX)
      begin
        digits_nxt = MSC_DIGITS_MAX;
      end
      else if (DIGIT_COUNT < MSC_DIGITS_MIN)
      begin
        digits_nxt = MSC_DIGITS_MIN;
      end
      else
      begin
        digits_nxt = DIGIT_COUNT;
      end
    end
    if (N_PRESET_LOAD)
    begin
      npre_nxt = N_PRESET;
    end
  end

  // Set wins over a simultaneous read; a bit whose cause is still present survives the read
  always_comb
  begin
    done_nxt = done_r;
    ovr_nxt = ovr_r;
    sync_nxt = sync_r;
    if (status_read)
    begin
      done_nxt = 1'b0;
      ovr_nxt = MEM_FULL;
      // Sync error raised by an overrun shares its cause, so it survives while memory stays full
      sync_nxt = sync_r & ovr_r & MEM_FULL;
    end
    if (count_done_to_latch)
    begin
      done_nxt = 1'b1;
    end
    if (overrun_event)
    begin
      ovr_nxt = 1'b1;
    end
    if (sync_event)
    begin
      sync_nxt = 1'b1;
    end
  end

  // Occupancy is decoded live from memory but registered, so the status byte shows empty one clock after MEM_EMPTY
  always_comb
  begin
    if (MEM_EMPTY)
    begin
      occ = MSC_OCC_EMPTY;
    end
    else if (MEM_FULL)
    begin
      occ = MSC_OCC_FULL;
    end
    else if (MEM_HALF)
    begin
      occ = MSC_OCC_ABOVE_HALF;
    end
    else
    begin
      occ = MSC_OCC_BELOW_HALF;
    end
  end

  always_comb
  begin
    stb_nxt = 8'h00;
    stb_nxt[MSC_BIT_COUNT_DONE] = done_nxt;
    stb_nxt[MSC_BIT_OVERRUN] = ovr_nxt;
    stb_nxt[MSC_BIT_SYNC_ERR] = sync_nxt;
    stb_nxt[MSC_BIT_OCC_HIGH] = occ[1];
    stb_nxt[MSC_BIT_OCC_LOW] = occ[0];
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_r <= MSC_IDLE;
      dig_cnt_r <= 4'h0;
      digits_r <= MSC_DIGITS_RST;
      npre_r <= MSC_NPRESET_RST;
      fmt_r <= 1'b0;
      store_r <= 1'b0;
      sdig_r <= 4'h0;
      clr_r <= 1'b0;
      done_r <= 1'b0;
      ovr_r <= 1'b0;
      sync_r <= 1'b0;
      stb_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      dig_cnt_r <= dig_cnt_nxt;
      digits_r <= digits_nxt;
      npre_r <= npre_nxt;
      fmt_r <= fmt_nxt;
      store_r <= store_nxt;
      sdig_r <= sdig_nxt;
      clr_r <= clr_nxt;
      done_r <= done_nxt;
      ovr_r <= ovr_nxt;
      sync_r <= sync_nxt;
      stb_r <= stb_nxt;
    end
  end

  assign DATA_SEND_REQUEST = (state_r == MSC_XFER);
  assign STORE_STROBE = store_r;
  assign STORE_DIGIT = sdig_r;
  assign MEM_CLEAR = clr_r;
  assign BINARY_FORWARD = fmt_r;
  assign ACCUMULATING = (state_r != MSC_IDLE);
  assign STATUS_BYTE = stb_r;
  assign SERVICE_REQUEST = done_r | ovr_r | sync_r;
  assign STATUS_LATCH_RESET = status_read;

endmodule // msc_seq_status

`default_nettype wire
